// file: rtl/irq_ctrl.sv
// Purpose: Eight-level interrupt controller with command and data ports
// Assumes: Host strobes and request lines are synchronous to CLOCK
// Notes: Response memory is not reset; only data writes change it
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Control-mode command loads mode 6:5, low bits keep, set or clear bit 7
// - After select-mask command, data writes load the request mask
// - After select-auto command, data writes load the auto-clear register
// - After select-vector command, data writes fill that level's vector
// - Pending bits set on request edge, cleared when acknowledged
// - Pending bits settable, clearable, never readable (read select cannot reach 10); reset command clears them
// - Mask blocks a request but keeps it pending until unmasked
// - Only unmasked pending requests can raise the group interrupt
// - Reset command sets every mask bit
// - Acknowledge picks top pending level, clears pending, sets in-service
// - Auto-clear levels leave service at acknowledge end, others by command
// - Auto-clear never readable (read select cannot reach 11), cleared by reset command
// - Mode write-only, cleared by reset command, bits 0,2,7 in status
// - Mode bit 7 arms group interrupts to the CPU
// - Mode bits 6:5 choose the register a data-port read returns
// - Mode bit 4 picks rising or falling request edge
// - Mode bit 3 picks group output polarity, high when set
// - Mode bit 2 selects polled operation, suppressing the group output
// - Mode bit 1 set makes every acknowledge supply the level 0 vector
// - Fixed priority: level 0 highest, level 7 lowest
// - Rotating priority: last serviced level becomes lowest
// - Status read: bit 7 group pending, bits 2:0 top unmasked level
// - Vector memory unreadable and kept across the reset command
// - Clear-top-service command clears highest priority in-service bit
module irq_ctrl (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Host register port
  input wire irq_ctrl_pkg::host_req_s HOST_REQ,
  output logic [7:0] HOST_RDATA,
  output logic HOST_RVALID,
  // Peripheral request lines
  input wire logic [7:0] REQ_IN,
  // Interrupt to the CPU and acknowledge handshake
  output logic GROUP_INT_OUT,
  input wire logic ACK_REQ,
  output irq_ctrl_pkg::ack_resp_s ACK_RESP
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] pending_request_reg;
  logic [7:0] request_mask_reg;
  logic [7:0] in_service_reg;
  logic [7:0] auto_clear_reg;
  logic [7:0] controller_mode_reg;
  irq_ctrl_pkg::data_target_e target_reg;
  logic [2:0] vec_level_reg;
  logic [7:0] vec_mem [irq_ctrl_pkg::LEVELS];
  logic [2:0] last_serviced_reg;
  logic [7:0] req_prev_reg;
  logic req_armed_reg;
  irq_ctrl_pkg::ack_state_e ack_state_reg;
  logic [2:0] ack_level_reg;

  // ---------------------------------------------------------------
  // Priority search
  // ---------------------------------------------------------------
  // Lowest offset from the start level wins; bit 3 flags a hit
  function automatic logic [3:0] pick_level(input logic [7:0] bits,
                                            input logic [2:0] start);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = irq_ctrl_pkg::LEVELS - 1; i >= 0; i--) begin
      idx = start + 3'(i);
      if (bits[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [7:0] cmd;
  logic cmd_wr;
  logic data_wr;
  logic [7:0] one_hot;
  logic [2:0] prio_start;
  logic [7:0] unmasked;
  logic [3:0] top_pending;
  logic [3:0] top_service;
  logic [7:0] req_edge;
  logic ack_take;
  logic ack_end;
  logic [7:0] ack_clear;

  assign cmd = HOST_REQ.wdata;
  assign cmd_wr = HOST_REQ.wr & ~HOST_REQ.sel_data;
  assign data_wr = HOST_REQ.wr & HOST_REQ.sel_data;
  assign one_hot = 8'h01 << cmd[2:0];

  // Rotation starts just past the last serviced level
  assign prio_start = controller_mode_reg[irq_ctrl_pkg::MODE_ROTATE] ?
                      last_serviced_reg + 3'h1 : irq_ctrl_pkg::LEVEL_ZERO;
  assign unmasked = pending_request_reg & ~request_mask_reg;
  assign top_pending = pick_level(unmasked, prio_start);
  assign top_service = pick_level(in_service_reg, prio_start);

  // Edge choice; the arm flag hides the first sample after reset
  assign req_edge = req_armed_reg ?
    (controller_mode_reg[irq_ctrl_pkg::MODE_EDGE_POL] ?
     (REQ_IN & ~req_prev_reg) : (~REQ_IN & req_prev_reg)) :
    irq_ctrl_pkg::ALL_ZERO;

  assign ack_take = (ack_state_reg == irq_ctrl_pkg::ACK_IDLE) & ACK_REQ;
  assign ack_end = (ack_state_reg == irq_ctrl_pkg::ACK_DRIVE) & ~ACK_REQ;
  // Taken level leaves pending alongside a host write, unless a pending data write sets its bit
  assign ack_clear = (ack_take && top_pending[3]) ?
                     (8'h01 << top_pending[2:0]) :
                     irq_ctrl_pkg::ALL_ZERO;

  // ---------------------------------------------------------------
  // Request line sampling
  // ---------------------------------------------------------------
  // Previous level of each request line
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      req_prev_reg <= irq_ctrl_pkg::ALL_ZERO;
      req_armed_reg <= 1'b0;
    end else begin
      req_prev_reg <= REQ_IN;
      req_armed_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Pending requests
  // ---------------------------------------------------------------
  // Clears first, sets last, so a new edge is never lost
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      pending_request_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else begin
      if (cmd_wr) begin
        if (cmd == irq_ctrl_pkg::CMD_RESET ||
            cmd[7:3] == irq_ctrl_pkg::OP5_CLR_BOTH_ALL ||
            cmd[7:3] == irq_ctrl_pkg::OP5_CLR_PEND_ALL) begin
          pending_request_reg <= req_edge;
        end else if (cmd[7:3] == irq_ctrl_pkg::OP5_CLR_BOTH_ONE ||
                     cmd[7:3] == irq_ctrl_pkg::OP5_CLR_PEND_ONE) begin
          pending_request_reg <=
            (pending_request_reg & ~one_hot & ~ack_clear) | req_edge;
        end else begin
          pending_request_reg <=
            (pending_request_reg & ~ack_clear) | req_edge;
        end
      end else if (data_wr && target_reg == irq_ctrl_pkg::TGT_PENDING) begin
        pending_request_reg <=
          (pending_request_reg & ~ack_clear) | cmd | req_edge;
      end else begin
        pending_request_reg <=
          (pending_request_reg & ~ack_clear) | req_edge;
      end
    end
  end

  // ---------------------------------------------------------------
  // Request mask
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      request_mask_reg <= irq_ctrl_pkg::ALL_ONES;
    end else if (cmd_wr) begin
      if (cmd == irq_ctrl_pkg::CMD_RESET ||
          cmd[7:3] == irq_ctrl_pkg::OP5_SET_MASK_ALL) begin
        request_mask_reg <= irq_ctrl_pkg::ALL_ONES;
      end else if (cmd[7:3] == irq_ctrl_pkg::OP5_SET_MASK_ONE) begin
        request_mask_reg <= request_mask_reg | one_hot;
      end else if (cmd[7:3] == irq_ctrl_pkg::OP5_CLR_BOTH_ALL) begin
        request_mask_reg <= irq_ctrl_pkg::ALL_ZERO;
      end else if (cmd[7:3] == irq_ctrl_pkg::OP5_CLR_BOTH_ONE) begin
        request_mask_reg <= request_mask_reg & ~one_hot;
      end
    end else if (data_wr && target_reg == irq_ctrl_pkg::TGT_MASK) begin
      request_mask_reg <= cmd;
    end
  end

  // ---------------------------------------------------------------
  // In-service
  // ---------------------------------------------------------------
  // Commands outrank an acknowledge in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      in_service_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else if (cmd_wr && (cmd == irq_ctrl_pkg::CMD_RESET ||
                 cmd[7:3] == irq_ctrl_pkg::OP5_CLR_SVC_ALL)) begin
      in_service_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else if (cmd_wr && cmd[7:3] == irq_ctrl_pkg::OP5_CLR_SVC_ONE) begin
      in_service_reg <= in_service_reg & ~one_hot;
    end else if (cmd_wr && cmd[7:4] == irq_ctrl_pkg::OP4_CLR_TOP_SVC &&
                 top_service[3]) begin
      in_service_reg <= in_service_reg & ~(8'h01 << top_service[2:0]);
    end else if (ack_take && top_pending[3]) begin
      in_service_reg <= in_service_reg | (8'h01 << top_pending[2:0]);
    end else if (ack_end && auto_clear_reg[ack_level_reg]) begin
      in_service_reg <= in_service_reg & ~(8'h01 << ack_level_reg);
    end
  end

  // ---------------------------------------------------------------
  // Auto-clear
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      auto_clear_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else if (cmd_wr && cmd == irq_ctrl_pkg::CMD_RESET) begin
      auto_clear_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else if (data_wr && target_reg == irq_ctrl_pkg::TGT_AUTO) begin
      auto_clear_reg <= cmd;
    end
  end

  // ---------------------------------------------------------------
  // Mode register
  // ---------------------------------------------------------------
  // Illegal arm code 11 leaves the arm bit alone
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      controller_mode_reg <= irq_ctrl_pkg::ALL_ZERO;
    end else if (cmd_wr) begin
      if (cmd == irq_ctrl_pkg::CMD_RESET) begin
        controller_mode_reg <= irq_ctrl_pkg::ALL_ZERO;
      end else if (cmd[7:5] == irq_ctrl_pkg::OP3_LOAD_MODE_LOW) begin
        controller_mode_reg[4:0] <= cmd[4:0];
      end else if (cmd[7:4] == irq_ctrl_pkg::OP4_CTRL_MODE) begin
        controller_mode_reg[6:5] <= cmd[6:5];
        if (cmd[1:0] == irq_ctrl_pkg::ARM_SET) begin
          controller_mode_reg[irq_ctrl_pkg::MODE_MASTER_ARM] <= 1'b1;
        end else if (cmd[1:0] == irq_ctrl_pkg::ARM_CLEAR) begin
          controller_mode_reg[irq_ctrl_pkg::MODE_MASTER_ARM] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Data port target and vector memory
  // ---------------------------------------------------------------
  // Target survives the reset command; only hardware reset and select commands move it
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      target_reg <= irq_ctrl_pkg::TGT_PENDING;
      vec_level_reg <= irq_ctrl_pkg::LEVEL_ZERO;
    end else if (cmd_wr) begin
      if (cmd[7:4] == irq_ctrl_pkg::OP4_SEL_MASK) begin
        target_reg <= irq_ctrl_pkg::TGT_MASK;
      end else if (cmd[7:4] == irq_ctrl_pkg::OP4_SEL_AUTO) begin
        target_reg <= irq_ctrl_pkg::TGT_AUTO;
      end else if (cmd[7:3] == irq_ctrl_pkg::OP5_SEL_VECTOR) begin
        target_reg <= irq_ctrl_pkg::TGT_VECTOR;
        vec_level_reg <= cmd[2:0];
      end
    end
  end

  // No reset: contents are kept by design
  always_ff @(posedge CLOCK) begin
    if (data_wr && target_reg == irq_ctrl_pkg::TGT_VECTOR) begin
      vec_mem[vec_level_reg] <= cmd;
    end
  end

  // ---------------------------------------------------------------
  // Acknowledge handshake
  // ---------------------------------------------------------------
  // Vector held while the CPU keeps the acknowledge up
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ack_state_reg <= irq_ctrl_pkg::ACK_IDLE;
      ack_level_reg <= irq_ctrl_pkg::LEVEL_ZERO;
      last_serviced_reg <= irq_ctrl_pkg::LEVEL_ZERO;
      ACK_RESP <= '0;
    end else begin
      unique case (ack_state_reg)
        irq_ctrl_pkg::ACK_IDLE: begin
          if (ACK_REQ) begin
            ack_state_reg <= irq_ctrl_pkg::ACK_DRIVE;
            ack_level_reg <= top_pending[2:0];
            ACK_RESP.valid <= 1'b1;
            ACK_RESP.empty <= ~top_pending[3];
            ACK_RESP.vector <=
              controller_mode_reg[irq_ctrl_pkg::MODE_SINGLE_VEC] ?
              vec_mem[irq_ctrl_pkg::LEVEL_ZERO] :
              vec_mem[top_pending[2:0]];
            if (top_pending[3]) begin
              last_serviced_reg <= top_pending[2:0];
            end
          end
        end
        irq_ctrl_pkg::ACK_DRIVE: begin
          if (!ACK_REQ) begin
            ack_state_reg <= irq_ctrl_pkg::ACK_IDLE;
            ACK_RESP <= '0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Group interrupt output
  // ---------------------------------------------------------------
  // Idle level after reset is high since polarity resets to active low
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      GROUP_INT_OUT <= 1'b1;
    end else begin
      GROUP_INT_OUT <=
        ~(controller_mode_reg[irq_ctrl_pkg::MODE_OUT_POL] ^
          (top_pending[3] &
           controller_mode_reg[irq_ctrl_pkg::MODE_MASTER_ARM] &
           ~controller_mode_reg[irq_ctrl_pkg::MODE_POLLED]));
    end
  end

  // ---------------------------------------------------------------
  // Host reads
  // ---------------------------------------------------------------
  // Status ignores arm and polled so polling software still sees work
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      HOST_RDATA <= irq_ctrl_pkg::ALL_ZERO;
      HOST_RVALID <= 1'b0;
    end else begin
      HOST_RVALID <= HOST_REQ.rd;
      if (HOST_REQ.rd && !HOST_REQ.sel_data) begin
        HOST_RDATA <= irq_ctrl_pkg::ALL_ZERO;
        HOST_RDATA[irq_ctrl_pkg::ST_GROUP] <= top_pending[3];
        HOST_RDATA[irq_ctrl_pkg::ST_ROTATE] <=
          controller_mode_reg[irq_ctrl_pkg::MODE_ROTATE];
        HOST_RDATA[irq_ctrl_pkg::ST_POLLED] <=
          controller_mode_reg[irq_ctrl_pkg::MODE_POLLED];
        HOST_RDATA[irq_ctrl_pkg::ST_ARM] <=
          controller_mode_reg[irq_ctrl_pkg::MODE_MASTER_ARM];
        HOST_RDATA[2:0] <= top_pending[2:0];
      end else if (HOST_REQ.rd) begin
        unique case (controller_mode_reg[irq_ctrl_pkg::MODE_RSEL_HI:
                                         irq_ctrl_pkg::MODE_RSEL_LO])
          irq_ctrl_pkg::RSEL_SERVICE: HOST_RDATA <= in_service_reg;
          irq_ctrl_pkg::RSEL_MASK: HOST_RDATA <= request_mask_reg;
          irq_ctrl_pkg::RSEL_PENDING: HOST_RDATA <= pending_request_reg;
          irq_ctrl_pkg::RSEL_AUTO: HOST_RDATA <= auto_clear_reg;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/irq_ctrl_pkg.sv
// Purpose: Shared constants and types of the eight-level interrupt controller
// Assumes: 8-bit host data, 8 request levels, 8-bit vectors
// Notes: Command codes other than the reset code are compared against the top bits of a command byte
package irq_ctrl_pkg;

  // ---------------------------------------------------------------
  // Sizes and reset values
  // ---------------------------------------------------------------
  localparam int LEVELS = 8;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [2:0] LEVEL_ZERO = 3'h0;

  // ---------------------------------------------------------------
  // Mode register bit positions
  // ---------------------------------------------------------------
  localparam int MODE_MASTER_ARM = 7;
  localparam int MODE_RSEL_HI = 6;
  localparam int MODE_RSEL_LO = 5;
  localparam int MODE_EDGE_POL = 4;
  localparam int MODE_OUT_POL = 3;
  localparam int MODE_POLLED = 2;
  localparam int MODE_SINGLE_VEC = 1;
  localparam int MODE_ROTATE = 0;

  // ---------------------------------------------------------------
  // Status byte bit positions (command port read)
  // ---------------------------------------------------------------
  localparam int ST_GROUP = 7;
  localparam int ST_ROTATE = 5;
  localparam int ST_POLLED = 4;
  localparam int ST_ARM = 3;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [4:0] OP5_CLR_BOTH_ALL = 5'h02;
  localparam logic [4:0] OP5_CLR_BOTH_ONE = 5'h03;
  localparam logic [4:0] OP5_SET_MASK_ALL = 5'h06;
  localparam logic [4:0] OP5_SET_MASK_ONE = 5'h07;
  localparam logic [4:0] OP5_CLR_PEND_ALL = 5'h08;
  localparam logic [4:0] OP5_CLR_PEND_ONE = 5'h09;
  localparam logic [3:0] OP4_CLR_TOP_SVC = 4'h6;
  localparam logic [4:0] OP5_CLR_SVC_ALL = 5'h0E;
  localparam logic [4:0] OP5_CLR_SVC_ONE = 5'h0F;
  localparam logic [2:0] OP3_LOAD_MODE_LOW = 3'h4;
  localparam logic [3:0] OP4_CTRL_MODE = 4'hA;
  localparam logic [3:0] OP4_SEL_MASK = 4'hB;
  localparam logic [3:0] OP4_SEL_AUTO = 4'hC;
  localparam logic [4:0] OP5_SEL_VECTOR = 5'h1C;

  // Master arm control field of the control-mode command
  localparam logic [1:0] ARM_KEEP = 2'h0;
  localparam logic [1:0] ARM_SET = 2'h1;
  localparam logic [1:0] ARM_CLEAR = 2'h2;

  // Data port read selection
  localparam logic [1:0] RSEL_SERVICE = 2'h0;
  localparam logic [1:0] RSEL_MASK = 2'h1;
  localparam logic [1:0] RSEL_PENDING = 2'h2;
  localparam logic [1:0] RSEL_AUTO = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_PENDING = 2'b00,
    TGT_MASK = 2'b01,
    TGT_AUTO = 2'b10,
    TGT_VECTOR = 2'b11
  } data_target_e;

  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_DRIVE = 1'b1
  } ack_state_e;

  typedef struct packed {
    logic sel_data;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic valid;
    logic empty;
    logic [7:0] vector;
  } ack_resp_s;

endpackage

// file: test/cpu_ack_model.sv
// Purpose: Host CPU side of the acknowledge handshake
// Assumes: Inputs move on the falling edge
// Notes: A slow count stretches the cycle to test the hold behaviour
`timescale 1ns/1ps
`default_nettype none
module cpu_ack_model (
  // Clock
  input wire logic CLOCK,
  // Acknowledge handshake
  input wire irq_ctrl_pkg::ack_resp_s ACK_RESP,
  output logic ACK_REQ
);
  logic [7:0] got_vector;
  logic got_empty;
  initial ACK_REQ = 1'b0;
  // One acknowledge; held until the vector is seen, then released
  task automatic ack(input int slow);
    @(negedge CLOCK);
    ACK_REQ <= 1'b1;
    @(negedge CLOCK);
    for (int i = 0; i < 8 && ACK_RESP.valid !== 1'b1; i++) @(negedge CLOCK);
    got_vector = ACK_RESP.vector;
    got_empty = ACK_RESP.empty;
    repeat (slow) @(negedge CLOCK);
    ACK_REQ <= 1'b0;
    @(negedge CLOCK);
  endtask
endmodule
`default_nettype wire

// file: test/irq_ctrl_properties.sv
// Purpose: Port-level assertions for the interrupt controller
// Assumes: Only the top-level ports are visible
// Notes: Mode and masks are hidden, so several checks follow a reset command
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_properties (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // Host port
  input wire irq_ctrl_pkg::host_req_s HOST_REQ,
  input wire logic [7:0] HOST_RDATA,
  input wire logic HOST_RVALID,
  // Requests, group output and acknowledge
  input wire logic [7:0] REQ_IN,
  input wire logic GROUP_INT_OUT,
  input wire logic ACK_REQ,
  input wire irq_ctrl_pkg::ack_resp_s ACK_RESP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic rst_cmd;
  logic rd_only;
  logic [2:0] quiet_reg;
  assign rst_cmd = HOST_REQ.wr && !HOST_REQ.sel_data
    && HOST_REQ.wdata == irq_ctrl_pkg::CMD_RESET;
  assign rd_only = HOST_REQ.rd && !HOST_REQ.wr;
  // Cycles since anything that may move the group output; saturates
  always_ff @(posedge CLOCK) begin
    if (!NRST || HOST_REQ.wr || ACK_REQ || $changed(REQ_IN)) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_read_answer; HOST_REQ.rd |=> HOST_RVALID; endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read answer");
  property p_ack_answer; $rose(ACK_REQ) |=> ACK_RESP.valid; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no vector");
  property p_ack_hold;
    ACK_RESP.valid && ACK_REQ |=> ACK_RESP.valid && $stable(ACK_RESP.vector);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("vector dropped");
  property p_ack_drop; ACK_RESP.valid && !ACK_REQ |=> !ACK_RESP.valid; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("vector stuck");
  property p_rst_group; rst_cmd |-> ##2 GROUP_INT_OUT; endproperty
  a_rst_group: assert property (p_rst_group) else $error("group after reset");
  property p_rst_status;
    rst_cmd ##1 !HOST_REQ.wr ##1 rd_only && !HOST_REQ.sel_data |=>
      HOST_RDATA[7:3] == 5'h00;
  endproperty
  a_rst_status: assert property (p_rst_status) else $error("status");
  property p_rst_data;
    rst_cmd ##1 !HOST_REQ.wr ##1 rd_only && HOST_REQ.sel_data |=>
      HOST_RDATA == 8'h00;
  endproperty
  a_rst_data: assert property (p_rst_data) else $error("service read");
  property p_rst_empty;
    rst_cmd ##1 !HOST_REQ.wr ##1 ACK_REQ && !ACK_RESP.valid |=>
      ACK_RESP.empty;
  endproperty
  a_rst_empty: assert property (p_rst_empty) else $error("not empty");
  property p_group_quiet; quiet_reg == 3'h7 |-> $stable(GROUP_INT_OUT); endproperty
  a_group_quiet: assert property (p_group_quiet) else $error("group moved");
  // Main scenarios reached
  c_vector: cover property (ACK_RESP.valid && !ACK_RESP.empty);
  c_group: cover property ($fell(GROUP_INT_OUT));
  c_reset: cover property (rst_cmd);
endmodule
bind irq_ctrl irq_ctrl_properties u_props (.CLOCK(CLOCK), .NRST(NRST),
  .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA), .HOST_RVALID(HOST_RVALID),
  .REQ_IN(REQ_IN), .GROUP_INT_OUT(GROUP_INT_OUT), .ACK_REQ(ACK_REQ),
  .ACK_RESP(ACK_RESP));
`default_nettype wire

// file: test/irq_ctrl_test.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Inputs change on the falling edge of CLOCK
// Notes: Read select only reaches 00 (after reset) and 01 (arm command)
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_test;
  // ---------------------------------------------------------------
  // Clock, wiring and counters
  // ---------------------------------------------------------------
  logic clock;
  logic nrst;
  irq_ctrl_pkg::host_req_s host_req;
  logic [7:0] host_rdata;
  logic host_rvalid;
  logic [7:0] req_in;
  logic group_int_out;
  logic ack_req;
  irq_ctrl_pkg::ack_resp_s ack_resp;
  int miscompares;
  int n_tests;
  int cycles;
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  irq_ctrl DUT (.CLOCK(clock), .NRST(nrst), .HOST_REQ(host_req),
    .HOST_RDATA(host_rdata), .HOST_RVALID(host_rvalid), .REQ_IN(req_in),
    .GROUP_INT_OUT(group_int_out), .ACK_REQ(ack_req), .ACK_RESP(ack_resp));
  cpu_ack_model cpu (.CLOCK(clock), .ACK_RESP(ack_resp), .ACK_REQ(ack_req));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge clock);
    host_req <= '{sel, 1'b1, 1'b0, d};
    @(negedge clock);
    host_req <= '0;
  endtask
  // Read one port, compare the masked byte
  task automatic rchk(input logic sel, input logic [7:0] m, input logic [7:0] e);
    @(negedge clock);
    host_req <= '{sel, 1'b0, 1'b1, 8'h00};
    @(negedge clock);
    host_req <= '0;
    chk({7'h00, host_rvalid}, 8'h01);
    chk(host_rdata & m, e);
  endtask
  task automatic ackchk(input int slow, input logic [7:0] vec);
    cpu.ack(slow);
    chk(cpu.got_vector, vec);
    chk({7'h00, cpu.got_empty}, 8'h00);
  endtask
  // Group output settles two edges after its cause
  task automatic gchk(input logic e);
    repeat (4) @(negedge clock);
    chk({7'h00, group_int_out}, {7'h00, e});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    host_req = '0;
    req_in = 8'hFF;
    miscompares = 0;
    n_tests = 0;
    cycles = 0;
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    wr(0, 8'h00);
    rchk(0, 8'hF8, 8'h00);
    rchk(1, 8'hFF, 8'h00);
    wr(0, 8'hB0);
    wr(1, 8'hFC);
    wr(0, 8'hC0);
    wr(1, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(0, 8'hE0 | i[7:0]);
      wr(1, 8'h40 + i[7:0]);
    end
    req_in = 8'hFC;
    repeat (3) @(negedge clock);
    ackchk(2, 8'h40);
    ackchk(0, 8'h41);
    rchk(1, 8'hFF, 8'h01);
    wr(0, 8'h60);
    rchk(1, 8'hFF, 8'h00);
    wr(0, 8'hA1);
    rchk(1, 8'hFF, 8'hFC);
    req_in = 8'hDC;
    gchk(1);
    wr(0, 8'hB0);
    wr(1, 8'h00);
    gchk(0);
    rchk(0, 8'hFF, 8'h8D);
    wr(0, 8'h84);
    gchk(1);
    rchk(0, 8'hF8, 8'h98);
    wr(0, 8'h82);
    ackchk(0, 8'h40);
    wr(0, 8'h81);
    req_in = 8'hFF;
    repeat (3) @(negedge clock);
    req_in = 8'hBE;
    repeat (3) @(negedge clock);
    ackchk(0, 8'h46);
    ackchk(0, 8'h40);
    wr(0, 8'hA2);
    req_in = 8'hFB;
    gchk(1);
    wr(0, 8'h00);
    rchk(1, 8'hFF, 8'h00);
    wr(0, 8'hA0);
    rchk(1, 8'hFF, 8'hFF);
    wr(0, 8'hB0);
    wr(1, 8'h00);
    rchk(0, 8'h80, 8'h00);
    wr(1, 8'hF7);
    req_in = 8'hFF;
    repeat (3) @(negedge clock);
    req_in = 8'hF7;
    repeat (3) @(negedge clock);
    ackchk(0, 8'h43);
    // Rising request edges and active-high group output
    wr(0, 8'h98);
    gchk(0);
    req_in = 8'hFF;
    repeat (3) @(negedge clock);
    ackchk(0, 8'h43);
    wr(0, 8'h00);
    cpu.ack(0);
    chk({7'h00, cpu.got_empty}, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
